//--- pkg/hpsc_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef HPSC_DEFINES_SVH
`define HPSC_DEFINES_SVH
`define HPSC_PORT1_STATUS_CONTROL_OFS 8'h64
`define HPSC_ROUTE_TO_MAIN_FLAG_OFS   8'h60
`define HPSC_STRUCTURAL_PARAMS_OFS    8'h04
`define HPSC_PORT_EVENT_OFS           8'h68
`define HPSC_BIT_ATTACH_PRESENT       0
`define HPSC_BIT_ATTACH_CHANGE        1
`define HPSC_BIT_ENABLED              2
`define HPSC_BIT_RESUME               6
`define HPSC_BIT_SLEEP                7
`define HPSC_BIT_BUS_RESET            8
`define HPSC_BIT_MINUS_LINE           10
`define HPSC_BIT_PLUS_LINE            11
`define HPSC_BIT_POWER                12
`define HPSC_BIT_HANDOFF              13
`define HPSC_LED_LO                   14
`define HPSC_LED_HI                   15
`define HPSC_TEST_LO                  16
`define HPSC_TEST_HI                  19
`define HPSC_BIT_POWER_SWITCH         4
`define HPSC_BIT_PIND                 16
`define HPSC_PORTSC_RESET             32'h0000_2000
`define HPSC_PORTSC_WMASK             32'h00FF_F2C6
`define HPSC_STRUCT_RESET             32'h0001_0011
`define HPSC_POWER_SETTLE_MS          20
`define HPSC_CLOCK_HZ                 50000000
`define HPSC_POWER_SETTLE_CYC \
   (`HPSC_POWER_SETTLE_MS * (`HPSC_CLOCK_HZ / 1000))
`endif

//--- pkg/hpsc_pkg.sv
// types shared by the port status and control block
package hpsc_pkg;
   typedef enum logic [3:0] {
      HPSC_ST_OFF     = 4'h1,
      HPSC_ST_SETTLE  = 4'h2,
      HPSC_ST_READY   = 4'h4,
      HPSC_ST_UNUSED  = 4'h8
   } hpsc_pwr_t;
   typedef logic [31:0] hpsc_word_t;
endpackage

//--- src/hpsc_sync2.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module hpsc_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         resetn,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   always_comb begin
      meta_d = clk_en ? d : meta_q;
      q_d    = clk_en ? meta_q : q;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= meta_d;
         q      <= q_d;
      end
   end
endmodule

//--- src/hpsc_port_ctrl.sv
// port 1 status and control register with routing and power logic
//
// Notes on behaviour
// R1: reset only by power-up or controller reset
// R2: after reset: detached and disabled
// R3: with power switching, state writes need power
// R4: software waits power settle, up to 20 ms
// R5: test select zero normal, else test mode
// R6: indicator writes ignored without indicator capability
// R7: routing flag rising clears ownership bit
// R8: ownership held one while routing flag low
// R9: power bit behaviour follows switch capability
// R10: line state shows plus and minus levels
// R11: bus reset bit reads reset state
// R12: sleep bit reads suspended state
// R13: resume bit reads resume signalling
// R14: enable bit reads port enabled
// R15: attach change set on attach change
// R16: attach present reads peripheral attached
// R17: power off zeroes port status fields
// R18: software writes reserved bits with reset values
// R19: software sets routing flag last
// R20: attach change cleared by writing one
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "hpsc_defines.svh"
module hpsc_port_ctrl
   import hpsc_pkg::*;
#(
   parameter int POWER_SETTLE_CYC = `HPSC_POWER_SETTLE_CYC
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   input  wire logic        hc_reset,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic [31:0]      rdata,
   input  wire logic        attach_pin,
   input  wire logic        plus_line,
   input  wire logic        minus_line,
   input  wire logic        resume_pin,
   output logic             vbus_power_bit,
   output logic             companion_handoff,
   output logic [3:0]       test_select_field,
   output logic [1:0]       indicator_led_field,
   output logic             bus_reset_active,
   output logic             sleep_state,
   output logic             resume_signal,
   output logic             enabled_flag,
   output logic             power_stable
);
   logic [3:0] pins_s;
   hpsc_word_t portsc_q, portsc_d;
   hpsc_word_t struct_q, struct_d;
   logic       routing_flag_q, routing_flag_d;
   logic       attach_prev_q, attach_prev_d;
   hpsc_word_t rdata_q, rdata_d;
   hpsc_pwr_t  pwr_q, pwr_d;
   logic [20:0] settle_q, settle_d;
   logic [31:0] status_view;
   logic       vbus_power_d, handoff_d, bus_reset_d, sleep_d;
   logic       resume_d, enabled_d, stable_d;
   logic [3:0] test_select_d;
   logic [1:0] indicator_d;

   // async pins: two flops before any logic reads them
   hpsc_sync2 #(.W(4)) u_sync (
      .clock  (clock),
      .resetn (resetn),
      .clk_en (clk_en),
      .d      ({resume_pin, minus_line, plus_line, attach_pin}),
      .q      (pins_s)
   );

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   wire power_on = portsc_q[`HPSC_BIT_POWER];
   // without switching the port is powered, except in the cycle after a controller reset clears the power bit
   wire power_switch_capable = struct_q[`HPSC_BIT_POWER_SWITCH];
   wire port_wr = wr_en && hit(addr, `HPSC_PORT1_STATUS_CONTROL_OFS);

   always_comb begin
      portsc_d       = portsc_q;
      struct_d       = struct_q;
      routing_flag_d = routing_flag_q;
      attach_prev_d  = pins_s[0];
      if (wr_en && hit(addr, `HPSC_ROUTE_TO_MAIN_FLAG_OFS))
         routing_flag_d = wdata[0];
      if (wr_en && hit(addr, `HPSC_STRUCTURAL_PARAMS_OFS))
         struct_d = wdata & 32'h0001_0010;
      // R9: power bit follows capability
      if (!power_switch_capable)
         portsc_d[`HPSC_BIT_POWER] = 1'b1;
      else if (port_wr)
         portsc_d[`HPSC_BIT_POWER] = wdata[`HPSC_BIT_POWER];
      // R3: state changes only while powered
      if (port_wr && (!power_switch_capable
                      || (power_on && pwr_q == HPSC_ST_READY))) begin
         // R5: test select stored as written
         portsc_d[`HPSC_TEST_HI:`HPSC_TEST_LO] =
            wdata[`HPSC_TEST_HI:`HPSC_TEST_LO];
         // R6: indicator needs capability
         if (struct_q[`HPSC_BIT_PIND])
            portsc_d[`HPSC_LED_HI:`HPSC_LED_LO] =
               wdata[`HPSC_LED_HI:`HPSC_LED_LO];
         portsc_d[`HPSC_BIT_BUS_RESET] = wdata[`HPSC_BIT_BUS_RESET];
         portsc_d[`HPSC_BIT_SLEEP]     = wdata[`HPSC_BIT_SLEEP];
         // R13: software drives resume
         portsc_d[`HPSC_BIT_RESUME]    = wdata[`HPSC_BIT_RESUME];
         portsc_d[`HPSC_BIT_ENABLED]   = wdata[`HPSC_BIT_ENABLED]
                                         && pins_s[0];
         portsc_d[`HPSC_BIT_HANDOFF]   = wdata[`HPSC_BIT_HANDOFF];
         // R20: write one clears change
         if (wdata[`HPSC_BIT_ATTACH_CHANGE])
            portsc_d[`HPSC_BIT_ATTACH_CHANGE] = 1'b0;
      end
      // R15: change sets, wins over clear
      if (pins_s[0] != attach_prev_q)
         portsc_d[`HPSC_BIT_ATTACH_CHANGE] = 1'b1;
      // detach drops enable
      if (!pins_s[0])
         portsc_d[`HPSC_BIT_ENABLED] = 1'b0;
      // R7: rising routing flag gives port to main
      if (routing_flag_d && !routing_flag_q)
         portsc_d[`HPSC_BIT_HANDOFF] = 1'b0;
      // R8: low routing flag holds ownership
      if (!routing_flag_d)
         portsc_d[`HPSC_BIT_HANDOFF] = 1'b1;
      // power removed clears driven state
      if (!portsc_d[`HPSC_BIT_POWER])
         portsc_d = portsc_d & 32'h000F_3000;
      // R1: controller reset restores the port word
      if (hc_reset) begin
         portsc_d       = `HPSC_PORTSC_RESET;
         routing_flag_d = 1'b0;
      end
   end

   // R4: settle counter models supply ramp
   always_comb begin
      pwr_d    = pwr_q;
      settle_d = settle_q;
      unique case (pwr_q)
         HPSC_ST_OFF: begin
            if (power_on) begin
               pwr_d    = HPSC_ST_SETTLE;
               settle_d = '0;
            end
         end
         HPSC_ST_SETTLE: begin
            if (!power_on)
               pwr_d = HPSC_ST_OFF;
            else if (settle_q >= 21'(POWER_SETTLE_CYC - 1))
               pwr_d = HPSC_ST_READY;
            else
               settle_d = settle_q + 21'h1;
         end
         HPSC_ST_READY: begin
            if (!power_on)
               pwr_d = HPSC_ST_OFF;
         end
         default: pwr_d = HPSC_ST_OFF;
      endcase
      // controller reset also restarts the ramp
      if (hc_reset) begin
         pwr_d    = HPSC_ST_OFF;
         settle_d = '0;
      end
   end

   always_comb begin
      status_view = portsc_q;
      // R16: attach present from pin
      status_view[`HPSC_BIT_ATTACH_PRESENT] = pins_s[0];
      // R10: line levels, plus high bit
      status_view[`HPSC_BIT_PLUS_LINE]  = pins_s[1];
      status_view[`HPSC_BIT_MINUS_LINE] = pins_s[2];
      // R13: resume detected or driven
      // pin shows a far-end K, the stored bit our own drive
      status_view[`HPSC_BIT_RESUME] = power_on &&
         (pins_s[3] || portsc_q[`HPSC_BIT_RESUME]);
      // R17: unpowered fields read zero
      if (!power_on)
         status_view = status_view & 32'h000F_3C01;
      rdata_d = '0;
      if (rd_en) begin
         if (hit(addr, `HPSC_PORT1_STATUS_CONTROL_OFS))
            rdata_d = status_view;
         else if (hit(addr, `HPSC_ROUTE_TO_MAIN_FLAG_OFS))
            rdata_d = {31'h0, routing_flag_q};
         else if (hit(addr, `HPSC_STRUCTURAL_PARAMS_OFS))
            rdata_d = struct_q;
         else if (hit(addr, `HPSC_PORT_EVENT_OFS))
            rdata_d = {30'h0, pwr_q == HPSC_ST_READY, power_on};
      end
   end

   // R1: only power-up or controller reset
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         // R2: detached, disabled
         portsc_q       <= `HPSC_PORTSC_RESET;
         struct_q       <= `HPSC_STRUCT_RESET;
         routing_flag_q <= 1'b0;
         attach_prev_q  <= 1'b0;
         pwr_q          <= HPSC_ST_OFF;
         settle_q       <= '0;
         rdata_q        <= '0;
      end else if (clk_en) begin
         portsc_q       <= portsc_d;
         routing_flag_q <= routing_flag_d;
         pwr_q          <= pwr_d;
         settle_q       <= settle_d;
         struct_q       <= struct_d;
         attach_prev_q  <= attach_prev_d;
         rdata_q        <= rdata_d;
      end
   end

   // outputs lag the register by one cycle
   always_comb begin
      vbus_power_d  = portsc_q[`HPSC_BIT_POWER];
      handoff_d     = portsc_q[`HPSC_BIT_HANDOFF];
      test_select_d = portsc_q[`HPSC_TEST_HI:`HPSC_TEST_LO];
      indicator_d   = status_view[`HPSC_LED_HI:`HPSC_LED_LO];
      // R11: bus reset state
      bus_reset_d   = status_view[`HPSC_BIT_BUS_RESET];
      // R12: suspend state
      sleep_d       = status_view[`HPSC_BIT_SLEEP];
      resume_d      = status_view[`HPSC_BIT_RESUME];
      // R14: enabled state
      enabled_d     = status_view[`HPSC_BIT_ENABLED];
      stable_d      = pwr_q == HPSC_ST_READY;
   end

   // every output leaves a flop, no glitches on pins
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         vbus_power_bit      <= 1'b0;
         companion_handoff   <= 1'b1;
         test_select_field   <= 4'h0;
         indicator_led_field <= 2'h0;
         bus_reset_active    <= 1'b0;
         sleep_state         <= 1'b0;
         resume_signal       <= 1'b0;
         enabled_flag        <= 1'b0;
         power_stable        <= 1'b0;
      end else if (clk_en) begin
         vbus_power_bit      <= vbus_power_d;
         companion_handoff   <= handoff_d;
         test_select_field   <= test_select_d;
         indicator_led_field <= indicator_d;
         bus_reset_active    <= bus_reset_d;
         sleep_state         <= sleep_d;
         resume_signal       <= resume_d;
         enabled_flag        <= enabled_d;
         power_stable        <= stable_d;
      end
   end

   assign rdata = rdata_q;
endmodule

//--- tb/hpsc_port_ctrl_chk.sv
// port-level assertions for the port status and control block
`timescale 1ns/1ps
module hpsc_port_ctrl_chk #(
   parameter int POWER_SETTLE_CYC = 20
) (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        hc_reset,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [31:0] rdata,
   input wire logic        vbus_power_bit,
   input wire logic        companion_handoff,
   input wire logic [3:0]  test_select_field,
   input wire logic [1:0]  indicator_led_field,
   input wire logic        bus_reset_active,
   input wire logic        sleep_state,
   input wire logic        resume_signal,
   input wire logic        enabled_flag,
   input wire logic        power_stable
);
   logic        flag_q, flag_d;
   logic        cap_q, cap_d;
   logic [15:0] on_q, on_d;
   // routing flag and switch capability shadows, cycles with power on
   always_comb begin
      flag_d = flag_q;
      cap_d  = cap_q;
      if (hc_reset)
         flag_d = 1'b0;
      else if (wr_en && addr == 8'h60)
         flag_d = wdata[0];
      if (wr_en && addr == 8'h04)
         cap_d = wdata[4];
      on_d = vbus_power_bit ? on_q + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flag_q <= 1'b0;
         cap_q  <= 1'b1;
         on_q   <= 16'h0000;
      end else begin
         flag_q <= flag_d;
         cap_q  <= cap_d;
         on_q   <= on_d;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   a_hc_reset: assert property (
      hc_reset |-> ##2 (companion_handoff && !vbus_power_bit
         && !enabled_flag && test_select_field == 4'h0))
      else $error("port state kept through controller reset");
   a_rdata_idle: assert property (!rd_en |=> rdata == 32'h0)
      else $error("read data not zero outside a read");
   a_unmapped_rd: assert property (
      rd_en && !(addr inside {8'h04, 8'h60, 8'h64, 8'h68})
      |=> rdata == 32'h0)
      else $error("unmapped read returned data");
   a_power_quiet: assert property (
      !vbus_power_bit |-> !enabled_flag && !sleep_state && !resume_signal
         && !bus_reset_active && indicator_led_field == 2'h0)
      else $error("status shown with power off");
   a_flag_low: assert property (
      wr_en && addr == 8'h60 && !wdata[0] |-> ##[2:3] companion_handoff)
      else $error("ownership not held with flag low");
   a_flag_rise: assert property (
      wr_en && addr == 8'h60 && wdata[0] && !flag_q && !hc_reset
      |-> ##[2:3] !companion_handoff)
      else $error("ownership not dropped on flag rise");
   a_power_write: assert property (
      wr_en && addr == 8'h64 && !hc_reset && cap_q
      |-> ##2 vbus_power_bit == $past(wdata[12], 2))
      else $error("power bit did not follow write");
   a_power_forced: assert property (
      wr_en && addr == 8'h04 && !wdata[4] && !hc_reset
      |-> ##3 vbus_power_bit)
      else $error("power bit not forced without switching");
   a_test_select: assert property (
      wr_en && addr == 8'h64 && power_stable && vbus_power_bit
      && wdata[12] |-> ##2 test_select_field == $past(wdata[19:16], 2))
      else $error("test select did not follow write");
   a_settle_early: assert property (
      $rose(power_stable) |-> on_q >= POWER_SETTLE_CYC - 3)
      else $error("power reported stable too soon");
   a_settle_late: assert property (
      on_q == POWER_SETTLE_CYC + 4 |-> power_stable)
      else $error("power never reported stable");
endmodule

//--- tb/hpsc_periph_model.sv
// attached peripheral: attach pin, data lines and resume K-state
`timescale 1ns/1ps
module hpsc_periph_model (
   input  wire logic attached,
   input  wire logic resume_k,
   output logic      attach_pin,
   output logic      plus_line,
   output logic      minus_line,
   output logic      resume_pin
);
   // detached lines fall to the host pull-downs; idle J, resume K
   always_comb begin
      attach_pin = attached;
      plus_line  = attached && !resume_k;
      minus_line = attached && resume_k;
      resume_pin = attached && resume_k;
   end
endmodule

//--- tb/tb_host_port_status_control.sv
// self-checking bench for the port status and control block
`timescale 1ns/1ps
module tb_host_port_status_control
   import hpsc_pkg::*;
;
   localparam int SETTLE = 20;
   logic       clock = 1'b0, resetn = 1'b0, hc_reset = 1'b0, clk_en = 1'b1;
   logic       wr_en = 1'b0, rd_en = 1'b0, attached = 1'b0, resume_k = 1'b0;
   logic [7:0] addr = 8'h00;
   hpsc_word_t wdata = 32'h0, rdata, last_rd;
   logic       attach_pin, plus_line, minus_line, resume_pin, power_stable;
   logic       vbus_power_bit, companion_handoff, bus_reset_active;
   logic       sleep_state, resume_signal, enabled_flag;
   logic [3:0] test_select_field;
   logic [1:0] indicator_led_field;
   int         fail_count = 0, cmp_count = 0;
   hpsc_port_ctrl #(.POWER_SETTLE_CYC(SETTLE)) u_dut (
      .clock, .resetn, .clk_en, .hc_reset, .addr, .wdata, .wr_en,
      .rd_en, .rdata, .attach_pin, .plus_line, .minus_line, .resume_pin,
      .vbus_power_bit, .companion_handoff, .test_select_field,
      .indicator_led_field, .bus_reset_active, .sleep_state,
      .resume_signal, .enabled_flag, .power_stable);
   hpsc_periph_model u_peer (.attached, .resume_k, .attach_pin,
      .plus_line, .minus_line, .resume_pin);
   initial begin
      forever #10 clock = ~clock;
   end
   task automatic chk(input string what, input hpsc_word_t exp,
                      input hpsc_word_t got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input hpsc_word_t d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic rchk(input string what, input logic [7:0] a,
                       input hpsc_word_t exp, input hpsc_word_t mask);
      @(posedge clock);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 last_rd = rdata;
      chk(what, exp, last_rd & mask);
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic t_power_up();
      rchk("port word", 8'h64, 32'h2000, '1);
      rchk("params word", 8'h04, 32'h0001_0011, '1);
      rchk("unmapped word", 8'h10, 32'h0, '1);
      wr(8'h64, 32'h0005_0004);
      pause(2);
      rchk("unpowered word", 8'h64, 32'h2000, '1);
      wr(8'h64, 32'h1000);
      wr(8'h64, 32'h0003_1000);
      rchk("early power", 8'h68, 32'h1, '1);
      pause(SETTLE);
      rchk("settled power", 8'h68, 32'h3, '1);
      rchk("early write", 8'h64, 32'h3000, '1);
   endtask
   task automatic t_attach();
      @(posedge clock);
      attached <= 1'b1;
      pause(5);
      rchk("attach word", 8'h64, 32'h3803, '1);
      wr(8'h64, 32'h1006);
      pause(2);
      chk("enable out", 1, enabled_flag);
      rchk("enabled word", 8'h64, 32'h3805, '1);
      @(posedge clock);
      resume_k <= 1'b1;
      pause(5);
      chk("resume out", 1, resume_signal);
      rchk("resume word", 8'h64, 32'h3445, '1);
      @(posedge clock);
      resume_k <= 1'b0;
      pause(5);
      wr(8'h64, 32'h1044);
      pause(2);
      chk("driven resume", 1, resume_signal);
   endtask
   task automatic t_fields();
      for (int v = 15; v >= 0; v--) begin
         wr(8'h64, {12'h000, v[3:0], 16'h1004});
         pause(2);
         chk("test field", v, test_select_field);
      end
      wr(8'h64, 32'h9004);
      pause(2);
      chk("led field", 2, indicator_led_field);
      wr(8'h04, 32'h0011);
      wr(8'h64, 32'h5004);
      pause(2);
      chk("locked led", 2, indicator_led_field);
      wr(8'h04, 32'h0001_0011);
   endtask
   task automatic t_route_off();
      wr(8'h60, 32'h1);
      pause(3);
      chk("handoff main", 0, companion_handoff);
      wr(8'h60, 32'h0);
      pause(3);
      chk("handoff back", 1, companion_handoff);
      wr(8'h64, 32'h0);
      pause(2);
      chk("off enable", 0, enabled_flag);
      rchk("off fields", 8'h64, 32'h0, 32'hC1C6);
      wr(8'h64, 32'h1000);
      wr(8'h60, 32'h1);
      pause(4);
      @(posedge clock);
      hc_reset <= 1'b1;
      @(posedge clock);
      hc_reset <= 1'b0;
      pause(2);
      rchk("after hc reset", 8'h64, 32'h2000, 32'hFFFF_F3FE);
   endtask
   task automatic t_freeze();
      @(posedge clock);
      clk_en <= 1'b0;
      wr(8'h64, 32'h1000);
      pause(2);
      chk("frozen enable", 1, enabled_flag);
      @(posedge clock);
      clk_en <= 1'b1;
      rchk("thawed word", 8'h64, 32'hB805, '1);
   endtask
   task automatic t_no_switch();
      wr(8'h04, 32'h0000_0000);
      wr(8'h64, 32'h0000_0004);
      pause(2);
      chk("forced power", 1, vbus_power_bit);
      rchk("unswitched word", 8'h64, 32'h3805, '1);
      wr(8'h04, 32'h0001_0011);
   endtask
   task automatic end_sim();
      $display("compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      t_power_up();
      t_attach();
      t_fields();
      t_freeze();
      t_route_off();
      t_no_switch();
      end_sim();
   end
   initial begin
      repeat (3000) @(posedge clock);
      fail_count++;
      end_sim();
   end
endmodule
bind hpsc_port_ctrl hpsc_port_ctrl_chk #(
   .POWER_SETTLE_CYC(POWER_SETTLE_CYC)) u_chk (.clock, .resetn, .hc_reset,
   .addr, .wdata, .wr_en, .rd_en, .rdata, .vbus_power_bit,
   .companion_handoff, .test_select_field, .indicator_led_field,
   .bus_reset_active, .sleep_state, .resume_signal, .enabled_flag,
   .power_stable);
